// >>> core/swl_loader.sv
// synthesizer program word loader: three-wire serial input register,
// parallel latch of the active settings, ratio decode, power-mode
// decode and a phase/frequency detector on the divided signals.
// assumes all pins are asynchronous to clk_sys (synchronised here),
// and that rst is asserted at power-up.
//
// Overview of operation
// - strobe low: each serial clock rise shifts one data bit into register
// - main divider field seven bits, msb first, 64 to 127, default 71
// - reference post-scale bit defaults 0 (divide-by-2 on), 1 bypasses
// - main post-scale bit defaults 1 (bypass), 0 inserts divide-by-2
// - main post-scale bit 0 doubles ratio: 256 to 508 in steps 4
// - fixed divide-by-2 after main divider always present
// - main path from oscillator scaled by six: up to 1524 or 3048
// - default main path division from oscillator is 852
// - last four bits are second LO divider, msb first, 4 to 15
// - second LO divider field defaults to 10
// - fixed divide-by-2 after second LO divider: 8 to 30
// - total second LO division from oscillator 16 to 60, steps 4
// - strobe rising edge moves whole shifted word into active settings
// - power-down enable is word lsb, shifted first; LO lsb shifted last
// - power-up loads built-in default word without serial transfer
// - default total second LO division is 40
// - phase detector senses phase and frequency with no dead zone
// - power bits: 00 all run, 01 osc and loop, 11 off, 10 undefined
`timescale 1ns/1ps
`default_nettype none
`include "swl_consts.svh"

module swl_loader (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   ser_data,
  input  wire logic                   ser_clk,
  input  wire logic                   ser_strobe,
  input  wire logic                   ref_cmp_in,
  input  wire logic                   main_cmp_in,
  output logic [`SWL_WORD_W-1:0]      active_word,
  output logic                        powerdown_enable,
  output logic                        powerdown_type,
  output logic                        ref_postscale_select,
  output logic [`SWL_REF_W-1:0]       ref_divider_field,
  output logic                        main_postscale_select,
  output logic [`SWL_MAIN_W-1:0]      main_divider_field,
  output logic [`SWL_LO2_W-1:0]       lo2_divider_field,
  output logic [5:0]                  ref_total_ratio,
  output logic [8:0]                  main_pd_ratio,
  output logic [11:0]                 main_total_ratio,
  output logic [4:0]                  lo2_mixer_ratio,
  output logic [5:0]                  lo2_total_ratio,
  output logic                        amplifiers_on,
  output logic                        oscillator_on,
  output logic                        mixers_on,
  output logic                        lo2_on,
  output logic                        digital_loop_on,
  output logic                        word_range_error,
  output logic                        short_word,
  output logic                        pd_up,
  output logic                        pd_down
);

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [4:0] pins_s;
  logic       data_s;
  logic       sclk_s;
  logic       strobe_s;
  logic       ref_s;
  logic       main_s;

  // serial clock idles high and strobe may be either level at release;
  // starting both high keeps a false rise out of the first cycles
  swl_sync #(
    .W    (5),
    .INIT (5'h06)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({main_cmp_in, ref_cmp_in, ser_strobe, ser_clk, ser_data}),
    .q       (pins_s)
  );

  assign data_s   = pins_s[0];
  assign sclk_s   = pins_s[1];
  assign strobe_s = pins_s[2];
  assign ref_s    = pins_s[3];
  assign main_s   = pins_s[4];

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  // power-up image: the built-in default word, already decoded
  localparam swl_pkg::swl_state_s RST_ST = '{
    shift         : '0,
    count         : '0,
    sclk_prev     : 1'b1, // matches the idle-high serial clock
    strobe_prev   : 1'b1, // a strobe high at release is no latch
    ref_prev      : 1'b0,
    main_prev     : 1'b0,
    word          : `SWL_DEFAULT_WORD,
    ref_div       : `SWL_DEF_REF_DIV,
    main_div      : `SWL_DEF_MAIN_DIV,
    lo2_div       : `SWL_DEF_LO2_DIV,
    ref_total     : `SWL_DEF_REF_TOT,
    main_pd_ratio : `SWL_DEF_MAIN_PD,
    main_total    : `SWL_DEF_MAIN_TOT,
    lo2_mix_ratio : `SWL_DEF_LO2_MIX,
    lo2_total     : `SWL_DEF_LO2_TOT,
    pmode         : swl_pkg::SWL_PM_NORMAL,
    pwr_en        : `SWL_PWR_ALL_ON,
    range_err     : 1'b0,
    short_word    : 1'b0,
    up            : 1'b0,
    dn            : 1'b0
  };

  swl_pkg::swl_state_s st_q;
  swl_pkg::swl_state_s st_d;

  logic                   sclk_rise;
  logic                   strobe_rise;
  logic                   ref_rise;
  logic                   main_rise;
  logic [`SWL_WORD_W-1:0] w;
  logic [`SWL_REF_W-1:0]  rdiv;
  logic [`SWL_MAIN_W-1:0] ndiv;
  logic [`SWL_LO2_W-1:0]  ldiv;

  // edge detection on synchronised pins
  assign sclk_rise   = sclk_s & ~st_q.sclk_prev;
  assign strobe_rise = strobe_s & ~st_q.strobe_prev;
  assign ref_rise    = ref_s & ~st_q.ref_prev;
  assign main_rise   = main_s & ~st_q.main_prev;

  // fields of the word about to be latched; each field arrives msb
  // first while the word as a whole arrives lsb first, so every
  // field is bit-reversed relative to the word
  assign w    = st_q.shift;
  assign rdiv = {<<{w[`SWL_REF_LSB +: `SWL_REF_W]}};
  assign ndiv = {<<{w[`SWL_MAIN_LSB +: `SWL_MAIN_W]}};
  assign ldiv = {<<{w[`SWL_LO2_LSB +: `SWL_LO2_W]}};

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    st_d             = st_q;
    st_d.sclk_prev   = sclk_s;
    st_d.strobe_prev = strobe_s;
    st_d.ref_prev    = ref_s;
    st_d.main_prev   = main_s;

    // shift right so the first bit ends at the word lsb
    if (!strobe_s && sclk_rise) begin
      st_d.shift = {data_s, st_q.shift[`SWL_WORD_W-1:1]};
      if (st_q.count != `SWL_CNT_W'(`SWL_WORD_W)) begin
        st_d.count = st_q.count + `SWL_CNT_W'(1);
      end
    end

    // parallel load; ratios are decoded once here so outputs are flops
    if (strobe_rise) begin
      st_d.word       = w;
      st_d.count      = '0;
      st_d.short_word = (st_q.count != `SWL_CNT_W'(`SWL_WORD_W));
      st_d.ref_div    = rdiv;
      st_d.main_div   = ndiv;
      st_d.lo2_div    = ldiv;
      st_d.range_err  = (rdiv < `SWL_REF_MIN) || (ndiv < `SWL_MAIN_MIN) ||
                        (ldiv < `SWL_LO2_MIN);
      // reference: select 0 keeps the divide-by-2
      if (w[`SWL_REF_PS_BIT]) begin
        st_d.ref_total = {1'b0, rdiv};
      end else begin
        st_d.ref_total = {rdiv, 1'b0};
      end
      // fixed /2 always, optional /2 when select is 0; /3 and /2
      // prescalers make the oscillator ratio six times that
      if (w[`SWL_MAIN_PS_BIT]) begin
        st_d.main_pd_ratio = {1'b0, ndiv, 1'b0};
        st_d.main_total    = 12'(ndiv) * 12'h00C;
      end else begin
        st_d.main_pd_ratio = {ndiv, 2'b00};
        st_d.main_total    = 12'(ndiv) * 12'h018;
      end
      st_d.lo2_mix_ratio = {ldiv, 1'b0};
      st_d.lo2_total     = {ldiv, 2'b00};
      // power mode from (type, enable)
      case ({w[`SWL_PD_TYPE_BIT], w[`SWL_PD_EN_BIT]})
        2'b00: begin
          st_d.pmode  = swl_pkg::SWL_PM_NORMAL;
          st_d.pwr_en = `SWL_PWR_ALL_ON;
        end
        2'b01: begin
          st_d.pmode  = swl_pkg::SWL_PM_PARTIAL;
          st_d.pwr_en = `SWL_PWR_PARTIAL;
        end
        2'b11: begin
          st_d.pmode  = swl_pkg::SWL_PM_OFF;
          st_d.pwr_en = `SWL_PWR_ALL_OFF;
        end
        default: begin
          // undefined code: safest is to switch everything off
          st_d.pmode  = swl_pkg::SWL_PM_UNDEF;
          st_d.pwr_en = `SWL_PWR_ALL_OFF;
        end
      endcase
    end

    // tri-state detector: both set clears both, so coincident edges
    // still give a one-cycle pulse on each output (no dead zone)
    if (st_q.pwr_en[4]) begin
      st_d.up = (st_q.up | ref_rise) & ~(st_q.up & st_q.dn);
      st_d.dn = (st_q.dn | main_rise) & ~(st_q.up & st_q.dn);
    end else begin
      st_d.up = 1'b0;
      st_d.dn = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  // reset is the power-up event: the default word needs no transfer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= RST_ST;
    end else begin
      st_q <= st_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign active_word           = st_q.word;
  assign powerdown_enable      = st_q.word[`SWL_PD_EN_BIT];
  assign powerdown_type        = st_q.word[`SWL_PD_TYPE_BIT];
  assign ref_postscale_select  = st_q.word[`SWL_REF_PS_BIT];
  assign main_postscale_select = st_q.word[`SWL_MAIN_PS_BIT];
  assign ref_divider_field     = st_q.ref_div;
  assign main_divider_field    = st_q.main_div;
  assign lo2_divider_field     = st_q.lo2_div;
  assign ref_total_ratio       = st_q.ref_total;
  assign main_pd_ratio         = st_q.main_pd_ratio;
  assign main_total_ratio      = st_q.main_total;
  assign lo2_mixer_ratio       = st_q.lo2_mix_ratio;
  assign lo2_total_ratio       = st_q.lo2_total;
  // pwr_en bits: 0 amps, 1 oscillator, 2 mixers, 3 lo2, 4 loop
  assign amplifiers_on         = st_q.pwr_en[0];
  assign oscillator_on         = st_q.pwr_en[1];
  assign mixers_on             = st_q.pwr_en[2];
  assign lo2_on                = st_q.pwr_en[3];
  assign digital_loop_on       = st_q.pwr_en[4];
  assign word_range_error      = st_q.range_err;
  assign short_word            = st_q.short_word;
  assign pd_up                 = st_q.up;
  assign pd_down               = st_q.dn;

endmodule
`default_nettype wire

// >>> core/swl_consts.svh
// constants for the synthesizer program word loader: word layout,
// power-up default word, field limits and the default ratios.
// assumes a 20-bit word with the power-down enable bit at bit 0.
`ifndef SWL_CONSTS_SVH
`define SWL_CONSTS_SVH

// ------------------------------------------------------------------
// word layout
// ------------------------------------------------------------------
`define SWL_WORD_W        20
`define SWL_CNT_W         5
`define SWL_PD_EN_BIT     0
`define SWL_PD_TYPE_BIT   1
`define SWL_REF_PS_BIT    2
`define SWL_REF_LSB       3
`define SWL_REF_W         5
`define SWL_MAIN_PS_BIT   8
`define SWL_MAIN_LSB      9
`define SWL_MAIN_W        7
`define SWL_LO2_LSB       16
`define SWL_LO2_W         4

// ------------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------------
`define SWL_DEFAULT_WORD  20'h5E320
`define SWL_DEF_REF_DIV   5'h04
`define SWL_DEF_MAIN_DIV  7'h47
`define SWL_DEF_LO2_DIV   4'hA
`define SWL_DEF_REF_TOT   6'h08
`define SWL_DEF_MAIN_PD   9'h08E
`define SWL_DEF_MAIN_TOT  12'h354
`define SWL_DEF_LO2_MIX   5'h14
`define SWL_DEF_LO2_TOT   6'h28
`define SWL_REF_MIN       5'h04
`define SWL_MAIN_MIN      7'h40
`define SWL_LO2_MIN       4'h4
`define SWL_PWR_ALL_ON    5'h1F
`define SWL_PWR_PARTIAL   5'h12
`define SWL_PWR_ALL_OFF   5'h00

`endif

// >>> core/swl_pkg.sv
// types for the synthesizer program word loader.
// assumes swl_consts.svh is on the include path.
`include "swl_consts.svh"

package swl_pkg;

  // power mode, one-hot
  typedef enum logic [3:0] {
    SWL_PM_NORMAL  = 4'h1,
    SWL_PM_PARTIAL = 4'h2,
    SWL_PM_UNDEF   = 4'h4,
    SWL_PM_OFF     = 4'h8
  } swl_pmode_e;

  // whole state of the loader
  typedef struct packed {
    logic [`SWL_WORD_W-1:0] shift;
    logic [`SWL_CNT_W-1:0]  count;
    logic                   sclk_prev;
    logic                   strobe_prev;
    logic                   ref_prev;
    logic                   main_prev;
    logic [`SWL_WORD_W-1:0] word;
    logic [`SWL_REF_W-1:0]  ref_div;
    logic [`SWL_MAIN_W-1:0] main_div;
    logic [`SWL_LO2_W-1:0]  lo2_div;
    logic [5:0]             ref_total;
    logic [8:0]             main_pd_ratio;
    logic [11:0]            main_total;
    logic [4:0]             lo2_mix_ratio;
    logic [5:0]             lo2_total;
    swl_pmode_e             pmode;
    logic [4:0]             pwr_en;
    logic                   range_err;
    logic                   short_word;
    logic                   up;
    logic                   dn;
  } swl_state_s;

endpackage

// >>> core/swl_sync.sv
// two-flop synchroniser for a group of asynchronous inputs.
// assumes a synchronous active-high reset on the sampling clock.
`timescale 1ns/1ps
`default_nettype none

module swl_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } swl_sync_s;

  swl_sync_s st_q;
  swl_sync_s st_d;

  // first stage feeds only the second stage
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    // reset to the idle level of each pin, so release shows no edge
    if (rst) begin
      st_q <= '{s1: INIT, s2: INIT};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule
`default_nettype wire

// >>> tb/swl_host_model.sv
// host side of the three-wire programming bus: shifts words lsb first.
// assumes clk_sys only for aligning the first pin change off its edges.
`timescale 1ns/1ps
`default_nettype none

module swl_host_model (
  input  wire logic clk_sys,
  output logic      ser_data,
  output logic      ser_clk,
  output logic      ser_strobe
);
  // strobe low at power-up asks for the built-in default word
  initial begin
    ser_data = 1'b0;
    ser_clk = 1'b1;
    ser_strobe = 1'b0;
  end

  // 64 ns serial clock, idles high so it is set up before strobe moves
  task automatic send_word(input logic [20:0] w, input int n);
    @(negedge clk_sys);
    ser_strobe = 1'b0;
    #32;
    for (int i = 0; i < n; i++) begin
      ser_clk = 1'b0;
      ser_data = w[i];
      #32;
      ser_clk = 1'b1;
      #32;
    end
    ser_strobe = 1'b1;
    #32;
    ser_data = ~ser_data; // no pull: released line shows junk
  endtask

  // clock edges with strobe high, data wiggling, must change nothing
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      ser_clk = 1'b0;
      ser_data = ~ser_data;
      #32;
      ser_clk = 1'b1;
      #32;
    end
  endtask

  task automatic strobe_low();
    @(negedge clk_sys);
    ser_strobe = 1'b0;
  endtask
endmodule

`default_nettype wire

// >>> tb/swl_loader_sva.sv
// assertions on the loader outputs, bound into swl_loader.
// assumes one clk_sys domain with synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
`include "swl_consts.svh"

module swl_loader_sva (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        ser_strobe,
  input wire logic        ref_cmp_in,
  input wire logic [19:0] active_word,
  input wire logic        ref_postscale_select,
  input wire logic [4:0]  ref_divider_field,
  input wire logic        main_postscale_select,
  input wire logic [6:0]  main_divider_field,
  input wire logic [3:0]  lo2_divider_field,
  input wire logic [5:0]  ref_total_ratio,
  input wire logic [8:0]  main_pd_ratio,
  input wire logic [11:0] main_total_ratio,
  input wire logic [4:0]  lo2_mixer_ratio,
  input wire logic [5:0]  lo2_total_ratio,
  input wire logic        amplifiers_on,
  input wire logic        oscillator_on,
  input wire logic        digital_loop_on,
  input wire logic        pd_up,
  input wire logic        pd_down
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // --------------------------------------------------------------
  // ratios and field order
  // --------------------------------------------------------------
  a_ref_total: assert property (ref_total_ratio ==
    ref_divider_field * (ref_postscale_select ? 1 : 2)) else $error("ref total");
  a_main_pd: assert property (main_pd_ratio ==
    main_divider_field * (main_postscale_select ? 2 : 4)) else $error("main pd");
  a_main_total: assert property (main_total_ratio ==
    main_divider_field * (main_postscale_select ? 12 : 24)) else $error("main tot");
  a_lo2_mixer: assert property (lo2_mixer_ratio ==
    lo2_divider_field * 2) else $error("lo2 mixer");
  a_lo2_total: assert property (lo2_total_ratio ==
    lo2_divider_field * 4) else $error("lo2 total");
  a_field_order: assert property ({lo2_divider_field, main_divider_field[0]} ==
    {active_word[16], active_word[17], active_word[18], active_word[19],
     active_word[15]}) else $error("field order");
  a_power_map: assert property ({amplifiers_on, oscillator_on,
    digital_loop_on} == {active_word[1:0] == 2'h0, {2{~active_word[1]}}})
    else $error("power map");

  // --------------------------------------------------------------
  // latch timing and phase detector
  // --------------------------------------------------------------
  // a change of the settings needs a strobe seen high for two samples
  a_latch_cause: assert property ($changed(active_word) |->
    $past(ser_strobe, 2) && $past(ser_strobe, 3)) else $error("latch cause");
  a_reset_default: assert property ($fell(rst) |->
    active_word == `SWL_DEFAULT_WORD) else $error("reset default");
  a_pd_release: assert property (pd_up && pd_down |=>
    !pd_up && !pd_down) else $error("pd release");
  a_pd_up_cause: assert property ($rose(pd_up) |->
    $past(ref_cmp_in, 2)) else $error("pd up cause");

  c_latch: cover property ($changed(active_word));
  c_doubled: cover property (!main_postscale_select);
  c_pd_both: cover property (pd_up && pd_down);
endmodule

bind swl_loader swl_loader_sva swl_loader_sva_inst (.*);

`default_nettype wire

// >>> tb/swl_loader_tb.sv
// self-checking bench for swl_loader driven through the serial bus.
// assumes swl_host_model as the bus master and the checker bound in.
`timescale 1ns/1ps
`default_nettype none

module swl_loader_tb;
  logic        clk_sys, rst, ser_data, ser_clk, ser_strobe;
  logic        ref_cmp_in, main_cmp_in, powerdown_enable, powerdown_type;
  logic        ref_postscale_select, main_postscale_select;
  logic [19:0] active_word;
  logic [4:0]  ref_divider_field, lo2_mixer_ratio;
  logic [6:0]  main_divider_field;
  logic [3:0]  lo2_divider_field;
  logic [5:0]  ref_total_ratio, lo2_total_ratio;
  logic [8:0]  main_pd_ratio;
  logic [11:0] main_total_ratio;
  logic        amplifiers_on, oscillator_on, mixers_on, lo2_on;
  logic        digital_loop_on, word_range_error, short_word, pd_up, pd_down;
  int          err_count = 0;
  int          compares = 0;

  swl_loader swl_loader_inst (.*);
  swl_host_model swl_host_model_inst (.clk_sys(clk_sys), .ser_data(ser_data),
    .ser_clk(ser_clk), .ser_strobe(ser_strobe));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // fields go on the wire msb first, the word itself lsb first
  function automatic logic [6:0] rev(input logic [6:0] v, input int w);
    logic [6:0] r;
    r = '0;
    for (int i = 0; i < w; i++)
      r[i] = v[w-1-i];
    return r;
  endfunction

  function automatic logic [19:0] mk(input logic [1:0] pw, input logic rps,
    input logic [4:0] rf, input logic mps, input logic [6:0] mn,
    input logic [3:0] lo);
    logic [6:0] a;
    logic [6:0] c;
    a = rev({2'h0, rf}, 5);
    c = rev({3'h0, lo}, 4);
    return {c[3:0], rev(mn, 7), mps, a[4:0], rps, pw};
  endfunction

  task automatic apply(input logic [1:0] pw, input logic rps,
    input logic [4:0] rf, input logic mps, input logic [6:0] mn,
    input logic [3:0] lo);
    logic [19:0] w;
    logic        a;
    logic        o;
    w = mk(pw, rps, rf, mps, mn, lo);
    a = (pw == 2'h0);
    o = ~pw[1];
    swl_host_model_inst.send_word({1'b0, w}, 20);
    @(negedge clk_sys);
    check(active_word, w);
    check({powerdown_type, powerdown_enable}, pw);
    check({ref_divider_field, main_divider_field, lo2_divider_field},
          {rf, mn, lo});
    check(ref_total_ratio, rps ? rf : rf * 2);
    check(main_pd_ratio, mn * (mps ? 2 : 4));
    check(main_total_ratio, mn * (mps ? 12 : 24));
    check({lo2_mixer_ratio, lo2_total_ratio}, {5'(lo * 2), 6'(lo * 4)});
    check({ref_postscale_select, main_postscale_select}, {rps, mps});
    check({amplifiers_on, oscillator_on, mixers_on, lo2_on, digital_loop_on},
          {a, o, a, a, o});
    check({word_range_error, short_word},
          {rf < 4 || mn < 64 || lo < 4, 1'b0});
  endtask

  task automatic finish_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ref_cmp_in = 1'b0;
    main_cmp_in = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    check(active_word, mk(2'h0, 1'b0, 5'h04, 1'b1, 7'h47, 4'hA));
    check({main_total_ratio, lo2_total_ratio}, {12'h354, 6'h28});
    check({ref_postscale_select, main_postscale_select, ref_total_ratio},
          {2'h1, 6'h08});
    $display("test power-up default done");
    apply(2'h0, 1'b0, 5'h04, 1'b1, 7'h47, 4'hA);
    apply(2'h1, 1'b1, 5'h1F, 1'b0, 7'h7F, 4'hF);
    apply(2'h3, 1'b0, 5'h08, 1'b1, 7'h40, 4'h4);
    apply(2'h2, 1'b1, 5'h05, 1'b0, 7'h40, 4'h4);
    $display("test modes and ranges done");
    // strobe still high: clock edges must be ignored
    swl_host_model_inst.idle_clocks(8);
    check(active_word, mk(2'h2, 1'b1, 5'h05, 1'b0, 7'h40, 4'h4));
    // latch with no bits: the input register must still hold that word
    swl_host_model_inst.send_word(21'h0, 0);
    @(negedge clk_sys);
    check(active_word, mk(2'h2, 1'b1, 5'h05, 1'b0, 7'h40, 4'h4));
    check(short_word, 1'b1);
    swl_host_model_inst.send_word({mk(2'h0, 1'b0, 5'h09, 1'b1, 7'h50, 4'h7),
                                   1'b1}, 21);
    @(negedge clk_sys);
    check(active_word, mk(2'h0, 1'b0, 5'h09, 1'b1, 7'h50, 4'h7));
    swl_host_model_inst.send_word(21'h0, 19);
    @(negedge clk_sys);
    check(short_word, 1'b1);
    apply(2'h0, 1'b0, 5'h03, 1'b1, 7'h40, 4'h3);
    $display("test word length and range done");
    @(negedge clk_sys);
    ref_cmp_in = 1'b1;
    for (int i = 0; i < 8 && pd_up !== 1'b1; i++)
      @(negedge clk_sys);
    check({pd_up, pd_down}, 2'b10);
    main_cmp_in = 1'b1;
    for (int i = 0; i < 8 && pd_down !== 1'b1; i++)
      @(negedge clk_sys);
    check({pd_up, pd_down}, 2'b11);
    @(negedge clk_sys);
    check({pd_up, pd_down}, 2'b00);
    ref_cmp_in = 1'b0;
    main_cmp_in = 1'b0;
    apply(2'h3, 1'b0, 5'h04, 1'b1, 7'h47, 4'hA);
    ref_cmp_in = 1'b1;
    repeat (8) @(negedge clk_sys);
    check({pd_up, pd_down}, 2'b00);
    $display("test phase detector done");
    swl_host_model_inst.strobe_low();
    rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    check(active_word, mk(2'h0, 1'b0, 5'h04, 1'b1, 7'h47, 4'hA));
    $display("test second reset done");
    finish_test();
  end

  // watchdog well beyond the nine frames of up to about 1.4 us each
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule

`default_nettype wire
